// File: hdl/cbi_pkg.sv
package cbi_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // ---------------------------------------------------------------------------
  // Vectors, stack page and status layout
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_NMI_LO = 16'hfffa;
  localparam logic [15:0] VEC_NMI_HI = 16'hfffb;
  localparam logic [15:0] VEC_IRQ_LO = 16'hfffe;
  localparam logic [15:0] VEC_IRQ_HI = 16'hffff;
  localparam logic [7:0]  STACK_PAGE = 8'h01;
  localparam int          MASK_BIT   = 2;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOLD_WIN_NS   = 100;
  // Longest time, so it rounds down; never below one cycle.
  localparam int HOLD_WIN_CALC = HOLD_WIN_NS / CLK_PERIOD_NS;
  localparam int HOLD_WIN_CYC  = (HOLD_WIN_CALC < 1) ? 1 : HOLD_WIN_CALC;
  localparam logic [4:0] HOLD_WIN_CNT = 5'(HOLD_WIN_CYC);

  // ---------------------------------------------------------------------------
  // Interrupt entry sequence
  // ---------------------------------------------------------------------------
  typedef enum logic [5:0] {
    SEQ_IDLE   = 6'h01,
    SEQ_PUSH_H = 6'h02,
    SEQ_PUSH_L = 6'h04,
    SEQ_PUSH_P = 6'h08,
    SEQ_VEC_L  = 6'h10,
    SEQ_VEC_H  = 6'h20
  } cbi_seq_t;

endpackage : cbi_pkg

// File: hdl/cbi_fall.sv
`timescale 1ns/1ps
`default_nettype none

module cbi_fall (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic strobe_i,
  input  wire logic level_i,
  output logic      fall_o
);

  // ---------------------------------------------------------------------------
  // Sampled falling-edge detector
  // ---------------------------------------------------------------------------
  // The sample resets high, so a line already low at reset counts as an edge at the first strobe.
  logic smp;
  logic next_smp;
  logic next_fall;

  always_comb begin
    next_smp  = smp;
    next_fall = 1'b0;
    if (strobe_i) begin
      next_smp  = level_i;
      next_fall = smp & ~level_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp    <= 1'b1;
      fall_o <= 1'b0;
    end else if (ce_i) begin
      smp    <= next_smp;
      fall_o <= next_fall;
    end
  end

  a_fall_cause: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && strobe_i && smp && !level_i |=> fall_o)
    else $error("sampled falling edge gave no pulse");

endmodule : cbi_fall

`default_nettype wire

// File: hdl/cbi_top.sv
// Contract
// - Eight-bit bidirectional data bus, three-state drivers.
// - Drive data only while output enable high.
// - Read cycles always leave the data bus undriven.
// - Low ready in window halts, holding address.
// - Ready ignored in writes, honoured at next read.
// - Maskable request taken after instruction, mask clear.
// - Entry pushes program counter and status.
// - Maskable vector low FFFE, high FFFF.
// - No interrupt recognised while ready low.
// - Non-maskable falling edge ignores the mask.
// - Non-maskable vector low FFFA, high FFFB.
// - Sample in phase two, start next phase one.
// - Overflow-set falling edge, sampled phase one end.
`timescale 1ns/1ps
`default_nettype none

module cbi_top
  import cbi_pkg::*;
(
  input  wire logic                      ref_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      ce_i,
  input  wire logic                      phi1_i,
  input  wire logic                      phi2_i,
  input  wire logic                      data_bus_output_enable_i,
  input  wire logic                      cycle_ready_i,
  input  wire logic                      irq_n_i,
  input  wire logic                      nmi_n_i,
  input  wire logic                      set_overflow_n_i,
  input  wire logic                      rd_cycle_i,
  input  wire logic                      instr_done_i,
  input  wire logic [cbi_pkg::ADDR_W-1:0] fetch_addr_i,
  input  wire logic [cbi_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic [cbi_pkg::DATA_W-1:0] data_in_i,
  input  wire logic [cbi_pkg::ADDR_W-1:0] pc_i,
  input  wire logic [cbi_pkg::DATA_W-1:0] status_i,
  input  wire logic [cbi_pkg::DATA_W-1:0] sp_i,
  output logic      [cbi_pkg::ADDR_W-1:0] addr_o,
  output logic                            rw_o,
  output logic      [cbi_pkg::DATA_W-1:0] data_o,
  output logic                            data_oe_n_o,
  output logic                            hold_o,
  output logic                            int_busy_o,
  output logic      [cbi_pkg::DATA_W-1:0] sp_o,
  output logic                            pc_load_o,
  output logic      [cbi_pkg::ADDR_W-1:0] pc_new_o,
  output logic                            mask_set_o,
  output logic                            overflow_set_o
);
  import cbi_pkg::*;

  // ---------------------------------------------------------------------------
  // Phase tracking
  // ---------------------------------------------------------------------------
  logic       phi1_q;
  logic       phi2_q;
  logic [4:0] win_cnt;
  logic [4:0] next_win_cnt;
  logic       cyc_end;
  logic       phi1_end;
  logic       in_win;

  assign cyc_end  = phi2_q & ~phi2_i;
  assign phi1_end = phi1_q & ~phi1_i;
  // The halt window runs from phase one to a short time into phase two.
  assign in_win = phi1_i | (phi2_i & (win_cnt <= HOLD_WIN_CNT));

  always_comb begin
    next_win_cnt = win_cnt;
    if (!phi2_i) begin
      next_win_cnt = 5'h00;
    end else if (win_cnt != 5'h1f) begin
      next_win_cnt = win_cnt + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phi1_q  <= 1'b0;
      phi2_q  <= 1'b0;
      win_cnt <= 5'h00;
    end else if (ce_i) begin
      phi1_q  <= phi1_i;
      phi2_q  <= phi2_i;
      win_cnt <= next_win_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt and overflow sampling
  // ---------------------------------------------------------------------------
  logic nmi_fall;
  logic so_fall;
  logic irq_smp;
  logic nmi_pend;
  logic next_irq_smp;
  logic next_nmi_pend;
  logic take_nmi;
  logic take_irq;
  logic recog;
  cbi_seq_t state;

  cbi_fall u_nmi_edge (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .strobe_i  (phi2_i),
    .level_i   (nmi_n_i),
    .fall_o    (nmi_fall)
  );

  // The pulse leaves the edge detector's flop and goes straight out.
  cbi_fall u_so_edge (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .strobe_i  (phi1_end),
    .level_i   (set_overflow_n_i),
    .fall_o    (so_fall)
  );
  assign overflow_set_o = so_fall;

  // Recognition only at the end of an instruction's last cycle.
  assign recog    = cyc_end & instr_done_i & cycle_ready_i
                    & !int_busy_o & (state == SEQ_IDLE);
  assign take_nmi = recog & nmi_pend;
  assign take_irq = recog & !nmi_pend & irq_smp
                    & !status_i[MASK_BIT];

  always_comb begin
    next_irq_smp  = irq_smp;
    next_nmi_pend = nmi_pend;
    if (phi2_i) begin
      next_irq_smp = ~irq_n_i;
    end
    if (take_nmi) begin
      next_nmi_pend = 1'b0;
    end
    // A new edge in the clearing cycle is kept.
    if (nmi_fall) begin
      next_nmi_pend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_smp  <= 1'b0;
      nmi_pend <= 1'b0;
    end else if (ce_i) begin
      irq_smp  <= next_irq_smp;
      nmi_pend <= next_nmi_pend;
    end
  end

  // ---------------------------------------------------------------------------
  // Entry sequence and bus
  // ---------------------------------------------------------------------------
  cbi_seq_t          next_state;
  logic              sel_nmi;
  logic              next_sel_nmi;
  logic [15:0]       ret_pc;
  logic [15:0]       next_ret_pc;
  logic [7:0]        ret_p;
  logic [7:0]        next_ret_p;
  logic [7:0]        vec_lo;
  logic [7:0]        next_vec_lo;
  logic [7:0]        next_sp;
  logic              rd_now;
  logic              advance;
  logic [15:0]       cur_addr;
  logic [7:0]        cur_data;
  logic [15:0]       next_addr;
  logic              next_hold;
  logic              next_pc_load;
  logic              next_mask_set;
  logic [15:0]       next_pc_new;

  function automatic logic [15:0] vec_addr(input logic nmi, input logic hi);
    logic [15:0] v;
    v = nmi ? (hi ? VEC_NMI_HI : VEC_NMI_LO)
            : (hi ? VEC_IRQ_HI : VEC_IRQ_LO);
    return v;
  endfunction : vec_addr

  always_comb begin
    rd_now   = rd_cycle_i;
    cur_addr = fetch_addr_i;
    cur_data = wr_data_i;
    case (state)
      SEQ_IDLE: begin
      end
      SEQ_PUSH_H: begin
        rd_now   = 1'b0;
        cur_addr = {STACK_PAGE, sp_o};
        cur_data = ret_pc[15:8];
      end
      SEQ_PUSH_L: begin
        rd_now   = 1'b0;
        cur_addr = {STACK_PAGE, sp_o};
        cur_data = ret_pc[7:0];
      end
      SEQ_PUSH_P: begin
        rd_now   = 1'b0;
        cur_addr = {STACK_PAGE, sp_o};
        cur_data = ret_p;
      end
      SEQ_VEC_L: begin
        rd_now   = 1'b1;
        cur_addr = vec_addr(sel_nmi, 1'b0);
      end
      SEQ_VEC_H: begin
        rd_now   = 1'b1;
        cur_addr = vec_addr(sel_nmi, 1'b1);
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    next_hold = hold_o;
    if (!rd_now) begin
      next_hold = 1'b0;
    end else if (in_win) begin
      next_hold = ~cycle_ready_i;
    end
  end

  assign advance = cyc_end & !hold_o;

  always_comb begin
    next_state    = state;
    next_sel_nmi  = sel_nmi;
    next_ret_pc   = ret_pc;
    next_ret_p    = ret_p;
    next_vec_lo   = vec_lo;
    next_sp       = sp_o;
    next_pc_load  = 1'b0;
    next_mask_set = 1'b0;
    next_pc_new   = pc_new_o;
    case (state)
      SEQ_IDLE: begin
        next_sp = sp_i;
        if (take_nmi || take_irq) begin
          next_state   = SEQ_PUSH_H;
          next_sel_nmi = take_nmi;
          next_ret_pc  = pc_i;
          next_ret_p   = status_i;
        end
      end
      SEQ_PUSH_H, SEQ_PUSH_L, SEQ_PUSH_P: begin
        if (advance) begin
          next_sp    = sp_o - 8'h01;
          next_state = (state == SEQ_PUSH_H) ? SEQ_PUSH_L
                     : (state == SEQ_PUSH_L) ? SEQ_PUSH_P : SEQ_VEC_L;
        end
      end
      SEQ_VEC_L: begin
        if (advance) begin
          next_vec_lo = data_in_i;
          next_state  = SEQ_VEC_H;
        end
      end
      SEQ_VEC_H: begin
        if (advance) begin
          next_pc_new   = {data_in_i, vec_lo};
          next_pc_load  = 1'b1;
          next_mask_set = 1'b1;
          next_state    = SEQ_IDLE;
        end
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // While halted the address is frozen so slow memory sees a stable fetch.
  assign next_addr = hold_o ? addr_o : cur_addr;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state       <= SEQ_IDLE;
      sel_nmi     <= 1'b0;
      ret_pc      <= 16'h0000;
      ret_p       <= 8'h00;
      vec_lo      <= 8'h00;
      sp_o        <= 8'h00;
      addr_o      <= 16'h0000;
      rw_o        <= 1'b1;
      data_o      <= 8'h00;
      data_oe_n_o <= 1'b1;
      hold_o      <= 1'b0;
      int_busy_o  <= 1'b0;
      pc_load_o   <= 1'b0;
      pc_new_o    <= 16'h0000;
      mask_set_o  <= 1'b0;
    end else if (ce_i) begin
      state       <= next_state;
      sel_nmi     <= next_sel_nmi;
      ret_pc      <= next_ret_pc;
      ret_p       <= next_ret_p;
      vec_lo      <= next_vec_lo;
      sp_o        <= next_sp;
      addr_o      <= next_addr;
      rw_o        <= rd_now;
      data_o      <= cur_data;
      data_oe_n_o <= ~(data_bus_output_enable_i & ~rd_now);
      hold_o      <= next_hold;
      int_busy_o  <= (next_state != SEQ_IDLE);
      pc_load_o   <= next_pc_load;
      pc_new_o    <= next_pc_new;
      mask_set_o  <= next_mask_set;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_read_float: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rw_o |-> data_oe_n_o)
    else $error("data driven during a read cycle");

  a_oe_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && !data_bus_output_enable_i |=> data_oe_n_o)
    else $error("data driven with output enable low");

  a_write_nohold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !rw_o |-> !hold_o)
    else $error("halt taken in a write cycle");

  a_hold_addr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && hold_o |=> $stable(addr_o))
    else $error("address moved while halted");

  a_hold_enter: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && rd_now && phi1_i && !cycle_ready_i |=> hold_o)
    else $error("low ready in phase one did not halt");

  a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    take_irq |-> instr_done_i && !status_i[MASK_BIT] && cycle_ready_i)
    else $error("maskable request taken while masked");

  a_nmi_pend: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && nmi_fall |=> nmi_pend)
    else $error("non-maskable edge lost");

  a_irq_vec: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && state == SEQ_VEC_L && !sel_nmi && !hold_o
    |=> addr_o == VEC_IRQ_LO)
    else $error("wrong maskable vector address");

  a_nmi_vec: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && state == SEQ_VEC_H && sel_nmi && !hold_o
    |=> addr_o == VEC_NMI_HI)
    else $error("wrong non-maskable vector address");

  a_push_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ce_i && state == SEQ_PUSH_H |=> !rw_o && data_o == ret_pc[15:8])
    else $error("program counter high not pushed");

  a_mask_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pc_load_o |-> mask_set_o && !int_busy_o)
    else $error("entry finished without setting the mask");

  c_nmi_taken: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    take_nmi ##[1:200] pc_load_o);
  c_irq_taken: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    take_irq ##[1:200] pc_load_o);
  c_halted: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    hold_o ##1 hold_o ##1 !hold_o);

endmodule : cbi_top

`default_nettype wire

// File: testbench/cbi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module cbi_mem_model
  import cbi_pkg::*;
(
  input  wire logic                       ref_clk_i,
  input  wire logic [cbi_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                       rw_i,
  input  wire logic [cbi_pkg::DATA_W-1:0] data_i,
  input  wire logic                       data_oe_n_i,
  output logic      [cbi_pkg::DATA_W-1:0] data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] flip;

  initial begin
    flip = 8'h5a;
    mem[VEC_NMI_LO] = 8'h78;
    mem[VEC_NMI_HI] = 8'h56;
    mem[VEC_IRQ_LO] = 8'h34;
    mem[VEC_IRQ_HI] = 8'h12;
  end

  // A byte lands only while the processor really drives the bus.
  always @(posedge ref_clk_i) begin
    if (!rw_i && !data_oe_n_i) begin
      mem[addr_i] <= data_i;
    end
    flip <= ~flip;
  end

  // Outside reads the bus floats, so a changing pattern is shown.
  assign data_o = rw_i ? mem[addr_i] : flip;
endmodule : cbi_mem_model

`default_nettype wire

// File: testbench/cbi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cbi_top_tb;
  import cbi_pkg::*;
  logic        ref_clk_i, nrst_i, phi1, phi2, dboe, follow, rdy, rd, done;
  logic        irq_n, nmi_n, so_n, busy_q;
  logic [15:0] fetch, pc, addr_o, pc_new_o, vec;
  logic [7:0]  wr, st, sp, din, data_o, sp_o;
  logic        rw_o, data_oe_n_o, hold_o, int_busy_o, pc_load_o;
  logic        mask_set_o, overflow_set_o;
  logic [2:0]  ph;
  int          err_total, tests_run, n_load, n_mask, n_ovf, n_busy;

  cbi_top u_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .phi1_i(phi1), .phi2_i(phi2), .data_bus_output_enable_i(dboe),
    .cycle_ready_i(rdy), .irq_n_i(irq_n), .nmi_n_i(nmi_n),
    .set_overflow_n_i(so_n), .rd_cycle_i(rd), .instr_done_i(done),
    .fetch_addr_i(fetch), .wr_data_i(wr), .data_in_i(din), .pc_i(pc),
    .status_i(st), .sp_i(sp), .addr_o(addr_o), .rw_o(rw_o),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .hold_o(hold_o),
    .int_busy_o(int_busy_o), .sp_o(sp_o), .pc_load_o(pc_load_o),
    .pc_new_o(pc_new_o), .mask_set_o(mask_set_o),
    .overflow_set_o(overflow_set_o)
  );

  cbi_mem_model u_mem (
    .ref_clk_i(ref_clk_i), .addr_i(addr_o), .rw_i(rw_o), .data_i(data_o),
    .data_oe_n_i(data_oe_n_o), .data_o(din)
  );

  // ---------------------------------------------------------------------------
  // Clock, phases and monitor
  // ---------------------------------------------------------------------------
  initial ref_clk_i = 1'b0;
  always #4 ref_clk_i = ~ref_clk_i;

  // Eight clocks a bus cycle; gaps keep the phases apart.
  always @(posedge ref_clk_i) begin
    #1;
    ph   = ph + 3'h1;
    phi1 = (ph <= 3'h2);
    phi2 = (ph >= 3'h4) && (ph != 3'h7);
    if (follow) dboe = phi2;
  end

  always @(posedge ref_clk_i) begin
    if (pc_load_o === 1'b1) begin
      n_load++;
      vec = pc_new_o;
    end
    if (mask_set_o === 1'b1) n_mask++;
    if (overflow_set_o === 1'b1) n_ovf++;
    if (int_busy_o === 1'b1 && !busy_q) n_busy++;
    busy_q = (int_busy_o === 1'b1);
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_load(input int base);
    for (int i = 0; i < 200 && n_load == base; i++) step(1);
  endtask : wait_load

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_data_bus();
    follow = 1'b0;
    rd = 1'b0;
    wr = 8'ha5;
    dboe = 1'b1;
    step(2);
    chk("oe_n write", 16'h0, {15'h0, data_oe_n_o});
    chk("data write", 16'h00a5, {8'h0, data_o});
    chk("rw write", 16'h0, {15'h0, rw_o});
    dboe = 1'b0;
    step(2);
    chk("oe_n disabled", 16'h1, {15'h0, data_oe_n_o});
    dboe = 1'b1;
    rd = 1'b1;
    step(2);
    chk("oe_n read", 16'h1, {15'h0, data_oe_n_o});
    follow = 1'b1;
  endtask : t_data_bus

  task automatic t_hold();
    fetch = 16'h1234;
    step(8);
    while (!phi1) step(1);
    rdy = 1'b0;
    step(3);
    fetch = 16'h4321;
    step(8);
    chk("hold", 16'h1, {15'h0, hold_o});
    chk("held addr", 16'h1234, addr_o);
    rdy = 1'b1;
    step(16);
    chk("hold released", 16'h0, {15'h0, hold_o});
    rd = 1'b0;
    rdy = 1'b0;
    step(16);
    chk("hold in write", 16'h0, {15'h0, hold_o});
    rd = 1'b1;
    step(16);
    chk("hold next read", 16'h1, {15'h0, hold_o});
    rdy = 1'b1;
    step(16);
  endtask : t_hold

  task automatic t_irq();
    int base;
    int m;
    int b;
    base = n_load;
    m = n_mask;
    b = n_busy;
    rd = 1'b0;
    st = 8'h20;
    pc = 16'hc123;
    sp = 8'hf0;
    done = 1'b0;
    irq_n = 1'b0;
    step(24);
    chk("irq before done", 16'(b), 16'(n_busy));
    done = 1'b1;
    for (int i = 0; i < 40 && int_busy_o !== 1'b1; i++) step(1);
    irq_n = 1'b1;
    chk("irq busy", 16'h1, {15'h0, int_busy_o});
    chk("entry sp", 16'h00f0, {8'h0, sp_o});
    wait_load(base);
    chk("irq loads", 16'(base + 1), 16'(n_load));
    chk("irq vector", 16'h1234, vec);
    chk("irq mask set", 16'(m + 1), 16'(n_mask));
    chk("push pch", 16'h00c1, {8'h0, u_mem.mem[16'h01f0]});
    chk("push pcl", 16'h0023, {8'h0, u_mem.mem[16'h01ef]});
    chk("push status", 16'h0020, {8'h0, u_mem.mem[16'h01ee]});
  endtask : t_irq

  task automatic t_nmi();
    int b;
    int base;
    b = n_busy;
    st = 8'h24;
    irq_n = 1'b0;
    step(48);
    chk("masked irq", 16'(b), 16'(n_busy));
    irq_n = 1'b1;
    rd = 1'b1;
    rdy = 1'b0;
    step(8);
    nmi_n = 1'b0;
    step(8);
    nmi_n = 1'b1;
    step(32);
    chk("nmi while halted", 16'(b), 16'(n_busy));
    base = n_load;
    rdy = 1'b1;
    wait_load(base);
    chk("nmi loads", 16'(base + 1), 16'(n_load));
    chk("nmi vector", 16'h5678, vec);
  endtask : t_nmi

  task automatic t_overflow();
    int o;
    o = n_ovf;
    so_n = 1'b0;
    step(16);
    so_n = 1'b1;
    step(16);
    chk("overflow pulses", 16'(o + 1), 16'(n_ovf));
  endtask : t_overflow

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    {phi1, phi2, dboe, busy_q, rd} = 5'h0;
    {follow, rdy, irq_n, nmi_n, so_n, done} = 6'h3f;
    ph = 3'h0;
    fetch = 16'h0;
    pc = 16'h0;
    wr = 8'h0;
    st = 8'h24;
    sp = 8'hff;
    {err_total, tests_run, n_load, n_mask, n_ovf, n_busy} = '0;
    nrst_i = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    step(2);
    t_data_bus();
    t_hold();
    t_irq();
    t_nmi();
    t_overflow();
    tally_and_finish();
  end

  // The scenarios need well under a thousand clocks; twenty thousand is ample.
  initial begin
    #(20000 * 8);
    err_total++;
    tally_and_finish();
  end
endmodule : cbi_top_tb

`default_nettype wire
